// File: shared/gfx_engine_pkg.sv
// How it works
// - each output word applies the selected one of 256 raster operation codes, one per cycle
// - alu operands come from source queue, destination queue and pattern buffer
// - source and destination queues hold eight 64-bit words for page-mode bursts
// - read-modify-write reads a destination run first, then writes it back as a run
// - pattern buffer keeps a whole 8x8 pattern at 8, 16 or 32 bit pixels
// - pattern fills leave as long unbroken write bursts
// - all operations work at 8, 16 and 32 bit pixel depth
// - pitches of 640, 800, 1024, 1152, 1280, 1600 and 2048 pixels
// - display memory of 1, 2 or 4 megabytes is addressed
// - operations are set up through 32-bit registers written with full 32-bit accesses
// - registers other than pattern index and data are double buffered so the next operation loads during the current one
// - bitmap data written anywhere in the 64K-byte screen port window is accepted
// - monochrome font data from the screen port is queued in the source queue
// - monochrome bitmaps expand to colour pixels at the current depth
// - packed monochrome bitmaps in offscreen memory expand directly for cached fonts
// - blit, rectangle, pattern, line and text operations, all hardware clipped
package gfx_engine_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int WORD_W = 64;
  localparam int REG_W = 32;
  localparam int REG_AW = 6;
  localparam int QUEUE_DEPTH_DEF = 8;
  localparam int BYTE_AW = 22;
  localparam int WORD_AW = 19;
  localparam int COORD_W = 12;
  localparam int CNT_W = 13;
  localparam int PAT_ENTRIES = 64;
  localparam int SP_WINDOW_BYTES = 65536;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [5:0] OFF_CMD = 6'h00;
  localparam logic [5:0] OFF_DST_XY = 6'h04;
  localparam logic [5:0] OFF_SRC_ADDR = 6'h08;
  localparam logic [5:0] OFF_SIZE = 6'h0c;
  localparam logic [5:0] OFF_FG = 6'h10;
  localparam logic [5:0] OFF_BG = 6'h14;
  localparam logic [5:0] OFF_CLIP_X = 6'h18;
  localparam logic [5:0] OFF_CLIP_Y = 6'h1c;
  localparam logic [5:0] OFF_LINE_D = 6'h20;
  localparam logic [5:0] OFF_DST_BASE = 6'h24;
  localparam logic [5:0] OFF_PAT_IDX = 6'h28;
  localparam logic [5:0] OFF_PAT_DATA = 6'h2c;
  localparam int NUM_SHADOW = 10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CMD_ROP_LSB = 0;
  localparam int CMD_OP_LSB = 8;
  localparam int CMD_DEPTH_LSB = 11;
  localparam int CMD_PITCH_LSB = 13;
  localparam int CMD_MSIZE_LSB = 16;
  localparam int CMD_XNEG_BIT = 18;
  localparam int CMD_YNEG_BIT = 19;
  localparam int CMD_GO_BIT = 31;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [2:0] {OP_BLT, OP_RECT, OP_PAT, OP_LINE, OP_TEXT, OP_FONT} draw_op_t;
  localparam logic [1:0] DEPTH_8 = 2'h0;
  localparam logic [1:0] DEPTH_16 = 2'h1;
  localparam logic [1:0] DEPTH_32 = 2'h2;
  localparam logic [1:0] MSIZE_1MB = 2'h0;
  localparam logic [1:0] MSIZE_2MB = 2'h1;

  // pitch select to pixels per line
  function automatic logic [COORD_W-1:0] pitch_px(input logic [2:0] sel);
    case (sel)
      3'h0: pitch_px = 12'h280;
      3'h1: pitch_px = 12'h320;
      3'h2: pitch_px = 12'h400;
      3'h3: pitch_px = 12'h480;
      3'h4: pitch_px = 12'h500;
      3'h5: pitch_px = 12'h640;
      default: pitch_px = 12'h800;
    endcase
  endfunction

  // word address mask for the fitted memory size
  function automatic logic [WORD_AW-1:0] mem_mask(input logic [1:0] msize);
    case (msize)
      MSIZE_1MB: mem_mask = 19'h1ffff;
      MSIZE_2MB: mem_mask = 19'h3ffff;
      default: mem_mask = 19'h7ffff;
    endcase
  endfunction

  // colour replicated across a word at the given byte shift
  function automatic logic [WORD_W-1:0] rep_color(input logic [REG_W-1:0] c,
                                                  input logic [1:0] bsh);
    case (bsh)
      DEPTH_8: rep_color = {8{c[7:0]}};
      DEPTH_16: rep_color = {4{c[15:0]}};
      default: rep_color = {2{c}};
    endcase
  endfunction

  // code depends on the destination operand
  function automatic logic rop_uses_dst(input logic [7:0] r);
    rop_uses_dst = (r & 8'h55) != ((r >> 1) & 8'h55);
  endfunction

endpackage

// File: verilog/rop_alu.sv
`timescale 1ns/1ps
module rop_alu
  import gfx_engine_pkg::*;
#(
  parameter int W = WORD_W
) (
  // operation select
  input wire logic [7:0] rop_i,
  // operands
  input wire logic [W-1:0] pat_i,
  input wire logic [W-1:0] src_i,
  input wire logic [W-1:0] dst_i,
  // result
  output logic [W-1:0] res_o
);

  // ****************************************
  // per bit truth table lookup
  // ****************************************
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign res_o[i] = rop_i[{pat_i[i], src_i[i], dst_i[i]}];
  end

endmodule

// File: verilog/bitblt_graphics_engine.sv
`timescale 1ns/1ps
module bitblt_graphics_engine
  import gfx_engine_pkg::*;
#(
  parameter int QUEUE_DEPTH = QUEUE_DEPTH_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // host register window
  input wire logic reg_wr_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  output logic reg_ready_o,
  // screen port
  input wire logic sp_wr_i,
  input wire logic [REG_W-1:0] sp_data_i,
  output logic sp_ready_o,
  // status
  output logic busy_o,
  // frame buffer memory controller
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [WORD_AW-1:0] mem_addr_o,
  output logic [7:0] mem_be_o,
  output logic [WORD_W-1:0] mem_wdata_o,
  input wire logic mem_gnt_i,
  input wire logic mem_rvalid_i,
  input wire logic [WORD_W-1:0] mem_rdata_i
);

  localparam int QP = $clog2(QUEUE_DEPTH);

  if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 8 || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0) begin : g_chk
    $error("QUEUE_DEPTH must be 2, 4 or 8");
  end

  typedef enum logic [2:0] {S_IDLE, S_ROW, S_CHUNK, S_RDS, S_RDD, S_WR, S_NEXT} state_t;

  // ****************************************
  // declarations
  // ****************************************
  logic [REG_W-1:0] sh_q [NUM_SHADOW];
  logic [REG_W-1:0] act_q [NUM_SHADOW];
  logic [REG_W-1:0] pat_q [PAT_ENTRIES];
  logic [WORD_W-1:0] srcq_q [QUEUE_DEPTH];
  logic [WORD_W-1:0] dstq_q [QUEUE_DEPTH];
  logic [5:0] pat_idx_q;
  logic pend_q;
  state_t st_q;
  logic [COORD_W-1:0] x_q, y_q, rows_q;
  logic signed [COORD_W+1:0] err_q;
  logic [BYTE_AW-1:0] src_row_q, row_byte_q, row_end_q;
  logic [WORD_AW-1:0] cw_q, first_q, font_w_q;
  logic [CNT_W-1:0] wleft_q, chunk_q, iss_q, ret_q, rds_n_q;
  logic [5:0] mono_ptr_q;
  logic [QP-1:0] s_wp_q, s_rp_q, d_wp_q, d_rp_q;
  logic [QP:0] s_cnt_q, d_cnt_q;
  logic sp_half_q;
  logic [REG_W-1:0] sp_lo_q;
  logic req_q, we_q;
  logic [WORD_AW-1:0] addr_q;
  logic [7:0] be_q;
  logic [WORD_W-1:0] wdata_q;

  // ****************************************
  // host writes and double buffering
  // ****************************************
  wire logic reg_take = reg_wr_i && (reg_be_i == 4'hf) && !pend_q;
  wire logic go_wr = reg_take && reg_addr_i == OFF_CMD && reg_wdata_i[CMD_GO_BIT];
  wire logic start = pend_q && st_q == S_IDLE;
  wire logic [REG_W-1:0] sh_xy = sh_q[OFF_DST_XY[5:2]];
  wire logic [REG_W-1:0] sh_ld = sh_q[OFF_LINE_D[5:2]];
  wire logic sh_xmaj = sh_ld[LO_LSB +: COORD_W] >= sh_ld[HI_LSB +: COORD_W];
  wire logic [COORD_W-1:0] sh_maj = sh_xmaj ? sh_ld[LO_LSB +: COORD_W] : sh_ld[HI_LSB +: COORD_W];
  wire logic [COORD_W-1:0] sh_min = sh_xmaj ? sh_ld[HI_LSB +: COORD_W] : sh_ld[LO_LSB +: COORD_W];
  assign reg_ready_o = !pend_q;

  // shadow set, pending flag and hand over to the active set
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
      pat_idx_q <= 6'h00;
      for (int i = 0; i < NUM_SHADOW; i++) begin
        sh_q[i] <= '0;
        act_q[i] <= '0;
      end
    end else begin
      if (reg_take && reg_addr_i < OFF_PAT_IDX) begin
        sh_q[reg_addr_i[5:2]] <= reg_wdata_i;
      end
      if (reg_take && reg_addr_i == OFF_PAT_IDX) begin
        pat_idx_q <= reg_wdata_i[5:0];
      end else if (reg_take && reg_addr_i == OFF_PAT_DATA) begin
        pat_idx_q <= pat_idx_q + 6'h01;
      end
      if (go_wr) begin
        pend_q <= 1'b1;
      end else if (start) begin
        pend_q <= 1'b0;
      end
      if (start) begin
        act_q <= sh_q;
      end
    end
  end

  // pattern buffer, 64 entries of 32 bits
  always_ff @(posedge mclk_i) begin
    if (reg_take && reg_addr_i == OFF_PAT_DATA) begin
      pat_q[pat_idx_q] <= reg_wdata_i;
    end
  end

  // ****************************************
  // active field decode
  // ****************************************
  wire logic [REG_W-1:0] cmd = act_q[OFF_CMD[5:2]];
  wire logic [7:0] rop = cmd[CMD_ROP_LSB +: 8];
  wire draw_op_t op = draw_op_t'(cmd[CMD_OP_LSB +: 3]);
  wire logic is_blt = op == OP_BLT;
  wire logic is_line = op == OP_LINE;
  wire logic is_font = op == OP_FONT;
  wire logic mono_op = op == OP_TEXT || is_font;
  wire logic [1:0] bsh = cmd[CMD_DEPTH_LSB + 1] ? DEPTH_32 : cmd[CMD_DEPTH_LSB +: 2];
  wire logic uses_d = rop_uses_dst(rop);
  wire logic [REG_W-1:0] size = act_q[OFF_SIZE[5:2]];
  wire logic [REG_W-1:0] clx = act_q[OFF_CLIP_X[5:2]];
  wire logic [REG_W-1:0] cly = act_q[OFF_CLIP_Y[5:2]];
  wire logic [REG_W-1:0] ld = act_q[OFF_LINE_D[5:2]];
  wire logic xmaj = ld[LO_LSB +: COORD_W] >= ld[HI_LSB +: COORD_W];
  wire logic [COORD_W-1:0] dmaj = xmaj ? ld[LO_LSB +: COORD_W] : ld[HI_LSB +: COORD_W];
  wire logic [COORD_W-1:0] dmin = xmaj ? ld[HI_LSB +: COORD_W] : ld[LO_LSB +: COORD_W];
  wire logic [COORD_W-1:0] x_step = cmd[CMD_XNEG_BIT] ? x_q - 12'h001 : x_q + 12'h001;
  wire logic [COORD_W-1:0] y_step = cmd[CMD_YNEG_BIT] ? y_q - 12'h001 : y_q + 12'h001;
  wire logic [WORD_W-1:0] fg_rep = rep_color(act_q[OFF_FG[5:2]], bsh);
  wire logic [WORD_W-1:0] bg_rep = rep_color(act_q[OFF_BG[5:2]], bsh);

  // ****************************************
  // row geometry
  // ****************************************
  wire logic [14:0] pitch_b = 15'(pitch_px(cmd[CMD_PITCH_LSB +: 3])) << bsh;
  wire logic [BYTE_AW-1:0] row_byte_d = BYTE_AW'(act_q[OFF_DST_BASE[5:2]][BYTE_AW-1:0]
    + y_q * pitch_b + (BYTE_AW'(x_q) << bsh));
  wire logic [COORD_W-1:0] row_w = is_line ? 12'h001 : size[LO_LSB +: COORD_W];
  wire logic [BYTE_AW-1:0] row_end_d = row_byte_d + (BYTE_AW'(row_w) << bsh) - 22'h000001;
  wire logic [CNT_W-1:0] nwords_d = CNT_W'(row_end_d[BYTE_AW-1:3] - row_byte_d[BYTE_AW-1:3])
    + 13'h0001;

  // ****************************************
  // chunk sizing
  // ****************************************
  wire logic [6:0] mono_cap = (7'h40 - {1'b0, mono_ptr_q}) >> (2'h3 - bsh);
  wire logic need_rd = is_blt || uses_d || is_font;
  wire logic [CNT_W-1:0] n0 = (need_rd && wleft_q > CNT_W'(QUEUE_DEPTH)) ? CNT_W'(QUEUE_DEPTH)
    : wleft_q;
  wire logic [CNT_W-1:0] chunk_d = (mono_op && n0 > CNT_W'(mono_cap)) ? CNT_W'(mono_cap) : n0;
  wire logic [CNT_W-1:0] rds_d = is_blt ? chunk_d
    : (is_font && s_cnt_q == '0) ? 13'h0001 : 13'h0000;

  // ****************************************
  // operands and alu
  // ****************************************
  wire logic [WORD_W-1:0] src_head = srcq_q[s_rp_q];
  wire logic [WORD_W-1:0] dst_head = dstq_q[d_rp_q];
  wire logic [4:0] pk = 5'(({2'h0, y_q[2:0]} << bsh) | (cw_q[4:0] & ((5'h01 << bsh) - 5'h01)));
  wire logic [WORD_W-1:0] pat_word = {pat_q[{pk, 1'b1}], pat_q[{pk, 1'b0}]};
  wire logic [5:0] mono_next = mono_ptr_q + 6'((7'h08 >> bsh));
  logic [WORD_W-1:0] mono_x, s_oper, d_oper, alu_res;
  logic [7:0] lane_en;

  // per byte colour expansion and clip enables
  for (genvar b = 0; b < 8; b++) begin : g_lane
    wire logic [BYTE_AW-1:0] gbyte = {cw_q, 3'(b)};
    wire logic [COORD_W-1:0] px = x_q + COORD_W'((gbyte - row_byte_q) >> bsh);
    assign mono_x[b*8 +: 8] = src_head[6'(mono_ptr_q + (6'(b) >> bsh))] ? fg_rep[b*8 +: 8]
      : bg_rep[b*8 +: 8];
    assign lane_en[b] = gbyte >= row_byte_q && gbyte <= row_end_q
      && px >= clx[LO_LSB +: COORD_W] && px <= clx[HI_LSB +: COORD_W]
      && y_q >= cly[LO_LSB +: COORD_W] && y_q <= cly[HI_LSB +: COORD_W];
  end

  // operand selection
  assign s_oper = is_blt ? src_head : mono_op ? mono_x : fg_rep;
  assign d_oper = uses_d ? dst_head : '0;

  rop_alu #(.W(WORD_W)) u_alu (
    .rop_i(rop),
    .pat_i(pat_word),
    .src_i(s_oper),
    .dst_i(d_oper),
    .res_o(alu_res)
  );

  // ****************************************
  // issue control
  // ****************************************
  wire logic out_free = !req_q || mem_gnt_i;
  wire logic src_ok = !(is_blt || mono_op) || s_cnt_q != '0;
  wire logic dst_ok = !uses_d || d_cnt_q != '0;
  wire logic want = (st_q == S_RDS && iss_q < rds_n_q) || (st_q == S_RDD && iss_q < chunk_q)
    || (st_q == S_WR && iss_q < chunk_q && src_ok && dst_ok);
  wire logic issue = out_free && want;
  wire logic wr_issue = issue && st_q == S_WR;
  wire logic [WORD_AW-1:0] rd_addr = st_q == S_RDD ? cw_q + WORD_AW'(iss_q)
    : is_font ? font_w_q : src_row_q[BYTE_AW-1:3] + (cw_q - first_q) + WORD_AW'(iss_q);
  wire logic rd_done = iss_q == rds_n_q && ret_q == rds_n_q && !req_q;
  wire logic rdd_done = iss_q == chunk_q && ret_q == chunk_q && !req_q;
  wire logic wr_done = iss_q == chunk_q && out_free;

  // ****************************************
  // source and destination queues
  // ****************************************
  assign sp_ready_o = s_cnt_q < (QP+1)'(QUEUE_DEPTH) && st_q != S_RDS;
  wire logic sp_take = sp_wr_i && sp_ready_o;
  wire logic s_push = (st_q == S_RDS && mem_rvalid_i) || (sp_take && sp_half_q);
  wire logic s_pop = wr_issue && (is_blt || (mono_op && mono_next == 6'h00))
    || (st_q == S_NEXT && rows_q == 12'h001 && mono_op && mono_ptr_q != '0);
  wire logic d_push = st_q == S_RDD && mem_rvalid_i;
  wire logic d_pop = wr_issue && uses_d;

  // queue storage and pointers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_wp_q <= '0;
      s_rp_q <= '0;
      s_cnt_q <= '0;
      d_wp_q <= '0;
      d_rp_q <= '0;
      d_cnt_q <= '0;
      sp_half_q <= 1'b0;
      sp_lo_q <= '0;
    end else begin
      if (sp_take) begin
        sp_half_q <= !sp_half_q;
        sp_lo_q <= sp_data_i;
      end
      if (s_push) begin
        srcq_q[s_wp_q] <= st_q == S_RDS ? mem_rdata_i : {sp_data_i, sp_lo_q};
        s_wp_q <= s_wp_q + 1'b1;
      end
      if (d_push) begin
        dstq_q[d_wp_q] <= mem_rdata_i;
        d_wp_q <= d_wp_q + 1'b1;
      end
      s_rp_q <= s_rp_q + QP'(s_pop);
      d_rp_q <= d_rp_q + QP'(d_pop);
      s_cnt_q <= s_cnt_q + (QP+1)'(s_push) - (QP+1)'(s_pop);
      d_cnt_q <= d_cnt_q + (QP+1)'(d_push) - (QP+1)'(d_pop);
    end
  end

  // ****************************************
  // memory request registers
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= '0;
      be_q <= 8'h00;
      wdata_q <= '0;
    end else if (out_free) begin
      req_q <= issue;
      if (issue) begin
        we_q <= st_q == S_WR;
        addr_q <= (st_q == S_WR ? cw_q : rd_addr) & mem_mask(cmd[CMD_MSIZE_LSB +: 2]);
        be_q <= st_q == S_WR ? lane_en : 8'hff;
        wdata_q <= alu_res;
      end
    end
  end

  assign mem_req_o = req_q;
  assign mem_we_o = we_q;
  assign mem_addr_o = addr_q;
  assign mem_be_o = be_q;
  assign mem_wdata_o = wdata_q;
  assign busy_o = st_q != S_IDLE || pend_q;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= S_IDLE;
      {x_q, y_q, rows_q} <= '0;
      err_q <= '0;
      {src_row_q, row_byte_q, row_end_q} <= '0;
      {cw_q, first_q, font_w_q} <= '0;
      {wleft_q, chunk_q, iss_q, ret_q, rds_n_q} <= '0;
      mono_ptr_q <= 6'h00;
    end else begin
      if (issue) begin
        iss_q <= iss_q + 13'h0001;
      end
      if (mem_rvalid_i && (st_q == S_RDS || st_q == S_RDD)) begin
        ret_q <= ret_q + 13'h0001;
      end
      if (issue && st_q == S_RDS && is_font) begin
        font_w_q <= font_w_q + 19'h00001;
      end
      if (wr_issue) begin
        cw_q <= cw_q + 19'h00001;
        wleft_q <= wleft_q - 13'h0001;
        if (mono_op) begin
          mono_ptr_q <= mono_next;
        end
      end
      unique case (st_q)
        S_IDLE: if (start) begin
          x_q <= sh_xy[LO_LSB +: COORD_W];
          y_q <= sh_xy[HI_LSB +: COORD_W];
          rows_q <= sh_q[OFF_SIZE[5:2]][HI_LSB +: COORD_W];
          src_row_q <= sh_q[OFF_SRC_ADDR[5:2]][BYTE_AW-1:0];
          font_w_q <= sh_q[OFF_SRC_ADDR[5:2]][BYTE_AW-1:3];
          err_q <= $signed({1'b0, sh_min, 1'b0}) - $signed({2'b00, sh_maj});
          mono_ptr_q <= 6'h00;
          if (sh_q[OFF_SIZE[5:2]][HI_LSB +: COORD_W] != '0) begin
            st_q <= S_ROW;
          end
        end
        S_ROW: begin
          row_byte_q <= row_byte_d;
          row_end_q <= row_end_d;
          cw_q <= row_byte_d[BYTE_AW-1:3];
          first_q <= row_byte_d[BYTE_AW-1:3];
          wleft_q <= row_w == '0 ? 13'h0000 : nwords_d;
          st_q <= row_w == '0 ? S_NEXT : S_CHUNK;
        end
        S_CHUNK: begin
          chunk_q <= chunk_d;
          rds_n_q <= rds_d;
          iss_q <= '0;
          ret_q <= '0;
          st_q <= rds_d != '0 ? S_RDS : uses_d ? S_RDD : S_WR;
        end
        S_RDS: if (rd_done) begin
          iss_q <= '0;
          ret_q <= '0;
          st_q <= uses_d ? S_RDD : S_WR;
        end
        S_RDD: if (rdd_done) begin
          iss_q <= '0;
          st_q <= S_WR;
        end
        S_WR: if (wr_done) begin
          st_q <= wleft_q == '0 ? S_NEXT : S_CHUNK;
        end
        S_NEXT: begin
          rows_q <= rows_q - 12'h001;
          src_row_q <= src_row_q + BYTE_AW'(pitch_b);
          st_q <= rows_q == 12'h001 ? S_IDLE : S_ROW;
          if (!is_line) begin
            y_q <= y_q + 12'h001;
          end else begin
            x_q <= (xmaj || err_q >= 0) ? x_step : x_q;
            y_q <= (!xmaj || err_q >= 0) ? y_step : y_q;
            err_q <= err_q >= 0 ? err_q + $signed({1'b0, dmin, 1'b0}) - $signed({1'b0, dmaj, 1'b0})
              : err_q + $signed({1'b0, dmin, 1'b0});
          end
        end
      endcase
    end
  end

endmodule

// File: bench/blit_checker.sv
`timescale 1ns/1ps
module blit_checker
  import gfx_engine_pkg::*;
#(
  parameter int QUEUE_DEPTH = QUEUE_DEPTH_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // host side
  input wire logic reg_wr_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [REG_W-1:0] reg_wdata_i,
  input wire logic reg_ready_o,
  input wire logic sp_wr_i,
  input wire logic [REG_W-1:0] sp_data_i,
  input wire logic sp_ready_o,
  input wire logic busy_o,
  // memory side
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [WORD_AW-1:0] mem_addr_o,
  input wire logic [7:0] mem_be_o,
  input wire logic [WORD_W-1:0] mem_wdata_o,
  input wire logic mem_gnt_i,
  input wire logic mem_rvalid_i,
  input wire logic [WORD_W-1:0] mem_rdata_i
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // accepted start command
  wire go_w = reg_wr_i && reg_ready_o && reg_be_i == 4'hf && reg_addr_i == OFF_CMD
              && reg_wdata_i[CMD_GO_BIT];
  chk_req_hold: assert property (mem_req_o && !mem_gnt_i |=> mem_req_o &&
    $stable(mem_addr_o) && $stable(mem_we_o)) else $error("request dropped before grant");
  chk_wdata_hold: assert property (mem_req_o && mem_we_o && !mem_gnt_i |=>
    $stable(mem_wdata_o) && $stable(mem_be_o)) else $error("write data moved before grant");
  chk_read_be: assert property (mem_req_o && !mem_we_o |-> mem_be_o == 8'hff)
    else $error("read without full byte enables");
  chk_req_busy: assert property (mem_req_o |-> busy_o)
    else $error("memory request while idle");
  chk_go_start: assert property (go_w |=> !reg_ready_o && busy_o)
    else $error("start command not taken");
  chk_part_be: assert property (!busy_o && reg_wr_i && reg_be_i != 4'hf |=> !busy_o)
    else $error("partial write started engine");
  chk_reset_idle: assert property (disable iff (1'b0) rst_i |=>
    !mem_req_o && !busy_o && reg_ready_o && sp_ready_o) else $error("bad reset state");
  chk_busy_end: assert property ($fell(busy_o) |-> !mem_req_o && reg_ready_o)
    else $error("busy fell with work left");
endmodule
bind bitblt_graphics_engine blit_checker #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_ready_o(reg_ready_o),
  .sp_wr_i(sp_wr_i), .sp_data_i(sp_data_i), .sp_ready_o(sp_ready_o), .busy_o(busy_o),
  .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o),
  .mem_wdata_o(mem_wdata_o), .mem_gnt_i(mem_gnt_i), .mem_rvalid_i(mem_rvalid_i),
  .mem_rdata_i(mem_rdata_i));

// File: bench/fb_mem_model.sv
`timescale 1ns/1ps
module fb_mem_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // requests
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [18:0] addr_i,
  // answers
  output logic gnt_o,
  output logic rvalid_o,
  output logic [63:0] rdata_o
);
  // ****************************************
  // stateless frame buffer
  // ****************************************
  logic [18:0] pend_q[$];
  // word contents derived from the address
  function automatic logic [63:0] rd_word(input logic [18:0] a);
    rd_word = {a ^ 19'h5a5a5, 13'h0b3, a, 13'h1c6};
  endfunction
  // random grant stalls, in-order read return after one cycle or more
  always @(posedge mclk_i) begin
    if (rst_i) begin
      gnt_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= 64'h0;
      pend_q.delete();
    end else begin
      gnt_o <= ($urandom % 4) != 0;
      if (pend_q.size() != 0 && ($urandom % 2) == 1) begin
        rvalid_o <= 1'b1;
        rdata_o <= rd_word(pend_q.pop_front());
      end else begin
        rvalid_o <= 1'b0;
        rdata_o <= ~rdata_o; // stale data never looks valid
      end
      if (req_i && gnt_o && !we_i) pend_q.push_back(addr_i);
    end
  end
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, g, e); end end
module tb;
  import gfx_engine_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic mclk_i = 0;
  logic rst_i = 1;
  logic reg_wr_i = 0;
  logic sp_wr_i = 0;
  logic [REG_AW-1:0] reg_addr_i = 0;
  logic [3:0] reg_be_i = 0;
  logic [REG_W-1:0] reg_wdata_i = 0;
  logic [REG_W-1:0] sp_data_i = 0;
  logic reg_ready_o, sp_ready_o, busy_o, mem_req_o, mem_we_o, mem_gnt_i, mem_rvalid_i;
  logic [WORD_AW-1:0] mem_addr_o;
  logic [7:0] mem_be_o;
  logic [WORD_W-1:0] mem_wdata_o, mem_rdata_i;
  int failures = 0;
  int n_tests = 0;
  logic [90:0] expq[$], exp_w;
  logic [31:0] pat[64];
  int pitches[8] = '{640, 800, 1024, 1152, 1280, 1600, 2048, 2048};
  always #50 mclk_i = ~mclk_i;
  bitblt_graphics_engine #(.QUEUE_DEPTH(8)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i),
    .reg_wdata_i(reg_wdata_i), .reg_ready_o(reg_ready_o), .sp_wr_i(sp_wr_i),
    .sp_data_i(sp_data_i), .sp_ready_o(sp_ready_o), .busy_o(busy_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o),
    .mem_wdata_o(mem_wdata_o), .mem_gnt_i(mem_gnt_i), .mem_rvalid_i(mem_rvalid_i),
    .mem_rdata_i(mem_rdata_i));
  fb_mem_model fbm (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .gnt_o(mem_gnt_i), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
  // granted writes against the oldest expected word
  always @(posedge mclk_i) begin
    if (!rst_i && mem_req_o && mem_gnt_i && mem_we_o) begin
      exp_w = expq.size() ? expq.pop_front() : 'x;
      `CHK({mem_be_o, mem_addr_o, mem_wdata_o}, exp_w)
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait on a level, one idle cycle first
  task automatic wait_for(input int which);
    int i;
    @(posedge mclk_i);
    #1;
    for (i = 0; i < 5000; i++) begin
      if ((which == 0 && reg_ready_o) || (which == 1 && sp_ready_o) || (which == 2 && !busy_o))
        break;
      @(posedge mclk_i);
      #1;
    end
    if (i == 5000) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic wreg(input logic [REG_AW-1:0] a, input logic [31:0] d,
                      input logic [3:0] be = 4'hf);
    wait_for(0);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_be_i = be;
    reg_wdata_i = d;
    @(posedge mclk_i);
    #1;
    reg_wr_i = 0;
  endtask
  task automatic spw(input logic [31:0] d);
    wait_for(1);
    sp_wr_i = 1;
    sp_data_i = d;
    @(posedge mclk_i);
    #1;
    sp_wr_i = 0;
  endtask
  // 8 px by 2 rows at a random depth, pitch, memory size and base
  task automatic run_op(input draw_op_t op, input logic [7:0] rop, input logic [63:0] mono);
    logic [1:0] dep, ms;
    logic [2:0] ps;
    logic [21:0] base, src;
    logic [31:0] fg, bg;
    logic [18:0] mask, wa;
    logic [63:0] p, s, d, m, res;
    int bpp, k;
    dep = 2'($urandom % 3);
    ps = 3'($urandom % 8);
    ms = 2'($urandom % 3);
    base = 22'($urandom) & 22'h3fffe0;
    src = 22'($urandom) & 22'h3ffff8;
    fg = $urandom;
    bg = $urandom;
    bpp = 1 << dep;
    mask = (19'h1 << (17 + ms)) - 19'h1;
    m = (op == OP_FONT) ? fbm.rd_word(19'(src >> 3) & mask) : mono;
    wreg(OFF_DST_BASE, {10'h0, base});
    wreg(OFF_SRC_ADDR, {10'h0, src});
    wreg(OFF_DST_XY, 32'h0);
    wreg(OFF_SIZE, 32'h0002_0008);
    wreg(OFF_FG, fg);
    wreg(OFF_BG, bg);
    wreg(OFF_CLIP_X, 32'h0fff_0000);
    wreg(OFF_CLIP_Y, 32'h0fff_0000);
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < bpp; c++) begin
        wa = 19'((base + r * pitches[ps] * bpp + c * 8) >> 3) & mask;
        d = fbm.rd_word(wa);
        s = fbm.rd_word(19'((src + r * pitches[ps] * bpp + c * 8) >> 3) & mask);
        k = r * bpp + c;
        p = {pat[2 * k + 1], pat[2 * k]};
        for (int b = 0; b < 8 && op != OP_BLT; b++) begin
          s[b * 8 +: 8] = 8'((m[r * 8 + c * (8 / bpp) + b / bpp] ? fg : bg) >> ((b % bpp) * 8));
        end
        for (int i = 0; i < 64; i++) res[i] = rop[{p[i], s[i], d[i]}];
        expq.push_back({8'hff, wa, res});
      end
    end
    wreg(OFF_CMD, {1'b1, 13'h0, ms, ps, dep, op, rop});
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    draw_op_t op;
    logic [63:0] mono;
    void'($urandom(38618));
    repeat (12) @(posedge mclk_i);
    #1;
    rst_i = 0;
    `CHK({busy_o, mem_req_o, reg_ready_o, sp_ready_o}, 4'h3)
    wreg(OFF_PAT_IDX, 32'h0);
    for (int i = 0; i < 64; i++) begin
      pat[i] = $urandom;
      wreg(OFF_PAT_DATA, pat[i]);
    end
    // partial byte enables are ignored
    wreg(OFF_CMD, 32'h8000_00cc, 4'h7);
    repeat (3) @(posedge mclk_i);
    #1;
    `CHK(busy_o, 1'b0)
    // every raster code as a blit, loaded while the previous one runs
    for (int r = 0; r < 256; r++) run_op(OP_BLT, 8'(r), 64'h0);
    wait_for(2);
    // pattern and rectangle fill, screen port text and cached font expansion
    for (int i = 0; i < 9; i++) begin
      op = (i % 3 == 0) ? (i % 2 ? OP_RECT : OP_PAT) : (i % 3 == 1) ? OP_TEXT : OP_FONT;
      mono = op < OP_TEXT ? '1 : {$urandom, $urandom};
      run_op(op, (op == OP_PAT) ? 8'h5a : 8'hcc, mono);
      if (op == OP_TEXT) begin
        spw(mono[31:0]);
        spw(mono[63:32]);
      end
      wait_for(2);
    end
    repeat (20) @(posedge mclk_i);
    `CHK(expq.size(), 0)
    report_and_stop();
  end
endmodule
